/* logic/psd_pkg.sv */
// Purpose: Shared constants for the program status and addressing block
// Assumes: Status doubleword bits are numbered 0 (left) to 63 (right)
// Notes: Vectors holding the doubleword are declared [0:63]
package psd_pkg;
  // Status doubleword field positions
  localparam int B_PRIV = 0;
  localparam int B_CC_LO = 1;
  localparam int B_CC_HI = 4;
  localparam int B_EXT = 5;
  localparam int B_LAST_RH = 6;
  localparam int B_MASK = 7;
  localparam int B_DISP_MODE = 8;
  localparam int B_DISP_MAPPED = 9;
  localparam int B_ADDR_LO = 13;
  localparam int B_ADDR_HI = 29;
  localparam int B_NEXT_RH = 30;
  localparam int B_DISP_BLOCK = 31;
  localparam int B_GRAN_LO = 32;
  localparam int B_GRAN_HI = 33;
  localparam int B_BASE_LO = 34;
  localparam int B_BASE_HI = 45;
  localparam int B_RETAIN = 47;
  localparam int B_INT_LO = 48;
  localparam int B_INT_HI = 49;
  localparam int B_CUR_LO = 50;
  localparam int B_CUR_HI = 61;
  // Bits kept in the stored copy; display-only and unused bits drop out
  localparam logic [0:63] PSD_KEEP_MASK = 64'hFF07_FFFE_FFFD_FFFC;
  localparam logic [0:63] PSD_RESET = 64'h8000_0000_0000_0000;
  // Field encodings
  localparam logic [1:0] GRAN_UNMAPPED = 2'h0;
  localparam logic [1:0] INT_UNBLOCK = 2'h0;
  localparam logic [1:0] INT_BLOCK = 2'h1;
  localparam logic DISP_PSD_MODE = 1'b1;
  // Storage and address sizes
  localparam int GPR_AW = 3;
  localparam int GPR_W = 32;
  localparam int MAP_AW = 7;
  localparam int MAP_W = 11;
  localparam int PHYS_W = 24;
  localparam int LOG_W = 19;
  localparam int BLOCK_LSB = 13;
  typedef enum logic [1:0] {
    MODE_BASIC = 2'b00,
    MODE_EXT = 2'b01,
    MODE_MAPPED = 2'b10,
    MODE_MAPPED_EXT = 2'b11
  } mode_type;
endpackage

/* logic/small_ram.sv */
// Purpose: Small register-array memory with a registered read port
// Assumes: Reset clears every word
// Notes: A read in the cycle of a write to the same word returns old data
`timescale 1ns/1ps
module small_ram import psd_pkg::*; #(
  parameter int AW = GPR_AW,
  parameter int W = GPR_W
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [W-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [W-1:0] o_rdata
);
  logic [W-1:0] mem_reg [2**AW];
  logic [W-1:0] mem_next [2**AW];
  logic [W-1:0] rdata_next;

  // Next contents and read data
  always_comb begin
    mem_next = mem_reg;
    if (i_we) begin
      mem_next[i_waddr] = i_wdata;
    end
    rdata_next = mem_reg[i_raddr];
  end

  // Reset clears every word, so no stale protection or data survives
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem_reg[i] <= '0;
      end
      o_rdata <= '0;
    end else begin
      mem_reg <= mem_next;
      o_rdata <= rdata_next;
    end
  end
endmodule

/* logic/addr_map.sv */
// Purpose: Turns a logical address into a physical one per addressing mode
// Assumes: Map entry arrives one cycle after the request
// Notes: Answer comes two cycles after the request
`timescale 1ns/1ps
module addr_map import psd_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic [PHYS_W-1:0] i_addr,
  input wire logic i_fetch,
  input wire logic i_ext_space,
  input wire mode_type i_mode,
  input wire logic [MAP_W-1:0] i_map_block,
  output logic [PHYS_W-1:0] o_phys_addr,
  output logic o_valid,
  output logic o_fault
);
  logic req_reg, req_next, fetch_reg, ext_reg;
  logic [PHYS_W-1:0] addr_reg;
  mode_type mode_reg;
  logic [PHYS_W-1:0] phys_next;
  logic fault_next;
  logic high;

  // Second stage: map entry is now valid, pick the physical address
  always_comb begin
    req_next = i_req;
    high = (addr_reg[PHYS_W-1:LOG_W] != '0);
    phys_next = {{(PHYS_W-LOG_W){1'b0}}, addr_reg[LOG_W-1:0]};
    fault_next = 1'b0;
    case (mode_reg)
      MODE_BASIC: fault_next = high || ext_reg;
      MODE_EXT: begin
        // Only operands may reach past the first 512 KB
        if (!fetch_reg && !ext_reg) begin
          phys_next = addr_reg;
        end
        fault_next = ext_reg || (fetch_reg && high);
      end
      MODE_MAPPED: begin
        phys_next = {i_map_block, addr_reg[BLOCK_LSB-1:0]};
        fault_next = high || ext_reg;
      end
      MODE_MAPPED_EXT: begin
        phys_next = {i_map_block, addr_reg[BLOCK_LSB-1:0]};
        fault_next = high || (fetch_reg && ext_reg);
      end
      default: fault_next = 1'b1;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      req_reg <= 1'b0;
      fetch_reg <= 1'b0;
      ext_reg <= 1'b0;
      addr_reg <= '0;
      mode_reg <= MODE_BASIC;
      o_phys_addr <= '0;
      o_valid <= 1'b0;
      o_fault <= 1'b0;
    end else begin
      req_reg <= req_next;
      fetch_reg <= i_fetch;
      ext_reg <= i_ext_space;
      addr_reg <= i_addr;
      mode_reg <= i_mode;
      o_phys_addr <= phys_next;
      o_valid <= req_reg;
      o_fault <= req_reg && fault_next;
    end
  end

  sequence s_basic_high;
    i_req && i_mode == MODE_BASIC && i_addr[PHYS_W-1:LOG_W] != '0;
  endsequence
  sequence s_ext_operand;
    i_req && i_mode == MODE_EXT && !i_fetch && !i_ext_space;
  endsequence

  a_basic_limit: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    s_basic_high |-> ##2 (o_valid && o_fault))
    else $error("basic mode accepted address past 512 KB");
  a_ext_operand: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    s_ext_operand |-> ##2 (o_valid && !o_fault &&
      o_phys_addr == $past(i_addr, 2)))
    else $error("extended operand address not passed through");
  a_fetch_primary: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (i_req && i_fetch && i_ext_space) |-> ##2 (o_valid && o_fault))
    else $error("fetch from extended operand space not refused");
endmodule

/* logic/psd_unit.sv */
// Purpose: Status doubleword, privilege control and addressing front end
// Assumes: Event inputs are one-cycle pulses synchronous to i_mclk
// Notes: Trap and status-load doublewords are supplied by the caller
`timescale 1ns/1ps

// Behaviour
// - Bit 0 set means privileged
// - Bits 1-4 hold four condition flags
// - Bit 5 selects extended addressing
// - Bit 6 marks last instruction right halfword
// - Bit 7 is arithmetic exception trap mask
// - Bits 8, 9, 31 only in display copy
// - Bits 13-29 hold logical word address
// - Bit 30 marks next right halfword
// - Bits 32-33 zero means unmapped
// - Bits 34-45 index base process entry
// - Bit 47 set keeps map contents
// - Bits 48-49 set or keep blocking
// - Bits 50-61 index current process; 62-63 unused
// - Map, halt, microcode writes are privileged
// - Unprivileged privileged op raises violation
// - Hardware traps load privileged doubleword
// - Fatal conditions also trap privileged
// - Monitor or supervisor call enters privilege
// - Status load replaces doubleword, may drop privilege
// - Reset clears registers, protection; sets privilege
// - Basic mode: direct 19-bit first 512 KB
// - Register field picks bit within byte
// - Extended mode: operands anywhere in 16 MB
// - Mapped mode translates primary space through map
// - Mapped extended maps operand-only second space
module psd_unit import psd_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_instr_done,
  input wire logic i_instr_right_half,
  input wire logic i_next_right_half,
  input wire logic [B_ADDR_HI-B_ADDR_LO:0] i_next_word_addr,
  input wire logic i_cc_we,
  input wire logic [3:0] i_cc_flags,
  input wire logic i_set_ext,
  input wire logic i_clear_ext,
  input wire logic i_instr_valid,
  input wire logic i_op_map_write,
  input wire logic i_op_halt,
  input wire logic i_op_wcs_write,
  input wire logic [MAP_AW-1:0] i_map_wr_index,
  input wire logic [MAP_W-1:0] i_map_wr_block,
  input wire logic i_trap_req,
  input wire logic [0:63] i_trap_psd,
  input wire logic i_svc_call,
  input wire logic i_load_status_instruction,
  input wire logic [0:63] i_load_status_instruction_psd,
  input wire logic i_gpr_we,
  input wire logic [GPR_AW-1:0] i_gpr_waddr,
  input wire logic [GPR_W-1:0] i_gpr_wdata,
  input wire logic [GPR_AW-1:0] i_gpr_raddr,
  input wire logic i_addr_req,
  input wire logic [PHYS_W-1:0] i_addr,
  input wire logic i_addr_fetch,
  input wire logic i_addr_ext_space,
  input wire logic [2:0] i_bit_sel,
  output logic [0:63] o_psd_stored,
  output logic [0:63] o_psd_display,
  output logic o_privileged,
  output logic o_blocked,
  output logic o_priv_violation,
  output logic o_arith_trap,
  output logic o_op_accept,
  output logic o_trap_taken,
  output logic o_map_reload,
  output logic [GPR_W-1:0] o_gpr_rdata,
  output logic [PHYS_W-1:0] o_phys_addr,
  output logic o_addr_valid,
  output logic o_addr_fault,
  output logic [7:0] o_bit_mask
);
  logic [0:63] psd_reg, psd_next;
  logic [0:63] disp_reg, disp_next;
  logic blocked_reg, blocked_next;
  logic viol_reg, viol_next;
  logic arith_reg, arith_next;
  logic accept_reg, accept_next;
  logic trap_reg, trap_next;
  logic reload_reg, reload_next;
  logic [7:0] bit_mask_reg, bit_mask_next;
  logic map_we;
  logic priv_op;
  logic [MAP_W-1:0] map_block;
  mode_type mode;

  // Map granularity field nonzero means mapped operation
  function automatic logic is_mapped(input logic [0:63] psd);
    is_mapped = (psd[B_GRAN_LO:B_GRAN_HI] != GRAN_UNMAPPED);
  endfunction

  // Build the display copy; marker bits never reach the stored copy
  function automatic logic [0:63] display_of(input logic [0:63] psd,
                                             input logic blk);
    logic [0:63] d;
    d = psd;
    d[B_DISP_MODE] = DISP_PSD_MODE;
    d[B_DISP_MAPPED] = is_mapped(psd);
    d[B_DISP_BLOCK] = blk;
    display_of = d;
  endfunction

  // Instruction classes that only privileged code may execute
  assign priv_op = i_op_map_write || i_op_halt || i_op_wcs_write;
  assign map_we = i_instr_valid && i_op_map_write && psd_reg[B_PRIV] &&
    !i_trap_req && !i_svc_call && !i_load_status_instruction;

  // Status doubleword update; traps outrank calls, calls outrank loads
  always_comb begin
    psd_next = psd_reg;
    blocked_next = blocked_reg;
    viol_next = 1'b0;
    arith_next = 1'b0;
    accept_next = 1'b0;
    trap_next = 1'b0;
    reload_next = 1'b0;
    if (i_trap_req) begin
      // Vectored doubleword, forced privileged
      psd_next = i_trap_psd & PSD_KEEP_MASK;
      psd_next[B_PRIV] = 1'b1;
      trap_next = 1'b1;
      reload_next = !i_trap_psd[B_RETAIN];
      if (i_trap_psd[B_INT_LO:B_INT_HI] == INT_UNBLOCK) begin
        blocked_next = 1'b0;
      end else if (i_trap_psd[B_INT_LO:B_INT_HI] == INT_BLOCK) begin
        blocked_next = 1'b1;
      end
    end else if (i_svc_call) begin
      psd_next = i_trap_psd & PSD_KEEP_MASK;
      psd_next[B_PRIV] = 1'b1;
      trap_next = 1'b1;
      reload_next = !i_trap_psd[B_RETAIN];
      if (i_trap_psd[B_INT_LO:B_INT_HI] == INT_UNBLOCK) begin
        blocked_next = 1'b0;
      end else if (i_trap_psd[B_INT_LO:B_INT_HI] == INT_BLOCK) begin
        blocked_next = 1'b1;
      end
    end else if (i_load_status_instruction) begin
      // Loading may reload the map, so it is itself privileged
      if (psd_reg[B_PRIV]) begin
        psd_next = i_load_status_instruction_psd & PSD_KEEP_MASK;
        reload_next = !i_load_status_instruction_psd[B_RETAIN];
        if (i_load_status_instruction_psd[B_INT_LO:B_INT_HI] == INT_UNBLOCK) begin
          blocked_next = 1'b0;
        end else if (i_load_status_instruction_psd[B_INT_LO:B_INT_HI] == INT_BLOCK) begin
          blocked_next = 1'b1;
        end
      end else begin
        viol_next = 1'b1;
      end
    end else begin
      if (i_instr_done) begin
        psd_next[B_LAST_RH] = i_instr_right_half;
        psd_next[B_NEXT_RH] = i_next_right_half;
        psd_next[B_ADDR_LO:B_ADDR_HI] = i_next_word_addr;
      end
      if (i_cc_we) begin
        psd_next[B_CC_LO:B_CC_HI] = i_cc_flags;
        arith_next = i_cc_flags[3] && psd_reg[B_MASK];
      end
      if (i_set_ext) begin
        psd_next[B_EXT] = 1'b1;
      end else if (i_clear_ext) begin
        psd_next[B_EXT] = 1'b0;
      end
      if (i_instr_valid) begin
        if (priv_op && !psd_reg[B_PRIV]) begin
          viol_next = 1'b1;
        end else begin
          accept_next = 1'b1;
        end
      end
    end
    disp_next = display_of(psd_next, blocked_next);
  end

  // Byte-internal bit select: bit 0 is the leftmost of the byte
  always_comb begin
    bit_mask_next = 8'h80 >> i_bit_sel;
  end

  // Reset leaves the processor privileged with protection removed
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      psd_reg <= PSD_RESET;
      disp_reg <= 64'h0000_0000_0000_0000;
      blocked_reg <= 1'b0;
      viol_reg <= 1'b0;
      arith_reg <= 1'b0;
      accept_reg <= 1'b0;
      trap_reg <= 1'b0;
      reload_reg <= 1'b0;
      bit_mask_reg <= 8'h00;
    end else begin
      psd_reg <= psd_next;
      disp_reg <= disp_next;
      blocked_reg <= blocked_next;
      viol_reg <= viol_next;
      arith_reg <= arith_next;
      accept_reg <= accept_next;
      trap_reg <= trap_next;
      reload_reg <= reload_next;
      bit_mask_reg <= bit_mask_next;
    end
  end

  assign o_psd_stored = psd_reg;
  assign o_psd_display = disp_reg;
  assign o_privileged = psd_reg[B_PRIV];
  assign o_blocked = blocked_reg;
  assign o_priv_violation = viol_reg;
  assign o_arith_trap = arith_reg;
  assign o_op_accept = accept_reg;
  assign o_trap_taken = trap_reg;
  assign o_map_reload = reload_reg;
  assign o_bit_mask = bit_mask_reg;

  // Mode follows the live doubleword; a pending load affects later requests
  assign mode = mode_type'({is_mapped(psd_reg), psd_reg[B_EXT]});

  // General registers; cleared by reset
  small_ram #(.AW(GPR_AW), .W(GPR_W)) gpr_file (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_we(i_gpr_we),
    .i_waddr(i_gpr_waddr),
    .i_wdata(i_gpr_wdata),
    .i_raddr(i_gpr_raddr),
    .o_rdata(o_gpr_rdata)
  );

  // Map: 64 primary blocks then 64 extended operand blocks of 8 KB
  small_ram #(.AW(MAP_AW), .W(MAP_W)) map_store (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_we(map_we),
    .i_waddr(i_map_wr_index),
    .i_wdata(i_map_wr_block),
    .i_raddr({i_addr_ext_space, i_addr[LOG_W-1:BLOCK_LSB]}),
    .o_rdata(map_block)
  );

  addr_map xlate (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_req(i_addr_req),
    .i_addr(i_addr),
    .i_fetch(i_addr_fetch),
    .i_ext_space(i_addr_ext_space),
    .i_mode(mode),
    .i_map_block(map_block),
    .o_phys_addr(o_phys_addr),
    .o_valid(o_addr_valid),
    .o_fault(o_addr_fault)
  );

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  sequence s_unpriv_op;
    i_instr_valid && priv_op && !o_privileged && !i_trap_req &&
      !i_svc_call && !i_load_status_instruction;
  endsequence
  sequence s_plain_load;
    i_load_status_instruction && o_privileged && !i_trap_req && !i_svc_call;
  endsequence

  a_priv_violation: assert property (
    s_unpriv_op |=> (o_priv_violation && !o_op_accept))
    else $error("unprivileged privileged op not refused");
  a_priv_accept: assert property (
    (i_instr_valid && o_privileged && !i_trap_req && !i_svc_call &&
      !i_load_status_instruction) |=> (o_op_accept && !o_priv_violation))
    else $error("privileged op refused in privileged state");
  a_trap_priv: assert property (
    i_trap_req |=> (o_privileged && o_trap_taken))
    else $error("trap did not enter privileged state");
  a_svc_priv: assert property (
    (i_svc_call && !i_trap_req) |=> (o_privileged && o_trap_taken))
    else $error("call did not enter privileged state");
  a_load_status_instruction_load: assert property (
    s_plain_load |=> (o_psd_stored == ($past(i_load_status_instruction_psd) & PSD_KEEP_MASK)))
    else $error("status load did not replace doubleword");
  a_unused_zero: assert property (
    (o_psd_stored & ~PSD_KEEP_MASK) == 64'h0000_0000_0000_0000)
    else $error("unused or display bit present in stored copy");
  a_block_keep: assert property (
    (s_plain_load and i_load_status_instruction_psd[B_INT_LO]) |=>
      (o_blocked == $past(o_blocked)))
    else $error("blocking mode changed on retain code");
  a_map_retain: assert property (
    (s_plain_load and i_load_status_instruction_psd[B_RETAIN]) |=> !o_map_reload)
    else $error("map reload requested despite retain bit");
  a_arith_trap: assert property (
    (i_cc_we && i_cc_flags[3] && o_psd_stored[B_MASK] && !i_trap_req &&
      !i_svc_call && !i_load_status_instruction) |=> o_arith_trap)
    else $error("masked-on arithmetic exception did not trap");
  a_disp_flags: assert property (
    ##1 (o_psd_display[B_DISP_MAPPED] ==
      (o_psd_stored[B_GRAN_LO:B_GRAN_HI] != GRAN_UNMAPPED) &&
      o_psd_display[B_DISP_BLOCK] == o_blocked))
    else $error("display copy flags disagree with state");
  a_reset_priv: assert property (
    $fell(i_rst) |-> (o_privileged && o_gpr_rdata == '0))
    else $error("reset did not leave privileged and cleared");
endmodule

/* tb/psd_vector_mem.sv */
// Purpose: Trap vector store in the shared memory of the main processor
// Assumes: Vector contents are fixed while the bench runs
// Notes: Entry 0 has bit 0 clear so forced privilege on a trap shows
`timescale 1ns/1ps
module psd_vector_mem (
  input wire logic i_sel,
  output logic [0:63] o_psd
);
  // Entry 0: extended, blocked, map reload; entry 1: privileged, map kept
  always_comb begin
    o_psd = i_sel ? 64'h8000_0000_0001_0000 : 64'h0400_0000_0000_4000;
  end
endmodule

/* tb/psd_unit_tb.sv */
// Purpose: Self-checking bench for the status doubleword block
// Assumes: Inputs change on the falling edge of i_mclk
// Notes: Each scenario is a task that judges its own results
`timescale 1ns/1ps
module psd_unit_tb import psd_pkg::*;;
  `define CMP(g, e, m) \
    begin \
      checks++; \
      if ((g) !== (e)) begin \
        bad_count++; \
        $display("mismatch at %0t: %s", $time, m); \
      end \
    end
  localparam logic [0:63] RST_DW = 64'h8000_0000_0000_0000;
  logic i_mclk, i_rst, i_instr_done, i_instr_right_half, i_next_right_half;
  logic [B_ADDR_HI-B_ADDR_LO:0] i_next_word_addr;
  logic i_cc_we, i_set_ext, i_clear_ext, i_instr_valid, vec_sel;
  logic [3:0] i_cc_flags;
  logic i_op_map_write, i_op_halt, i_op_wcs_write, i_trap_req, i_svc_call;
  logic [MAP_AW-1:0] i_map_wr_index;
  logic [MAP_W-1:0] i_map_wr_block;
  logic [0:63] i_trap_psd, i_load_status_instruction_psd, o_psd_stored, o_psd_display;
  logic i_load_status_instruction, i_gpr_we, i_addr_req, i_addr_fetch, i_addr_ext_space;
  logic [GPR_AW-1:0] i_gpr_waddr, i_gpr_raddr;
  logic [GPR_W-1:0] i_gpr_wdata, o_gpr_rdata;
  logic [PHYS_W-1:0] i_addr, o_phys_addr, ph;
  logic [2:0] i_bit_sel;
  logic o_privileged, o_blocked, o_priv_violation, o_arith_trap, o_op_accept;
  logic o_trap_taken, o_map_reload, o_addr_valid, o_addr_fault, fl;
  logic [7:0] o_bit_mask;
  int bad_count, checks;

  // Far side: trap vectors held in shared memory
  psd_vector_mem u_psd_vector_mem (.i_sel(vec_sel), .o_psd(i_trap_psd));

  psd_unit u_psd_unit (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_instr_done(i_instr_done),
    .i_instr_right_half(i_instr_right_half),
    .i_next_right_half(i_next_right_half),
    .i_next_word_addr(i_next_word_addr), .i_cc_we(i_cc_we),
    .i_cc_flags(i_cc_flags), .i_set_ext(i_set_ext),
    .i_clear_ext(i_clear_ext), .i_instr_valid(i_instr_valid),
    .i_op_map_write(i_op_map_write), .i_op_halt(i_op_halt),
    .i_op_wcs_write(i_op_wcs_write), .i_map_wr_index(i_map_wr_index),
    .i_map_wr_block(i_map_wr_block), .i_trap_req(i_trap_req),
    .i_trap_psd(i_trap_psd), .i_svc_call(i_svc_call), .i_load_status_instruction(i_load_status_instruction),
    .i_load_status_instruction_psd(i_load_status_instruction_psd), .i_gpr_we(i_gpr_we),
    .i_gpr_waddr(i_gpr_waddr), .i_gpr_wdata(i_gpr_wdata),
    .i_gpr_raddr(i_gpr_raddr), .i_addr_req(i_addr_req), .i_addr(i_addr),
    .i_addr_fetch(i_addr_fetch), .i_addr_ext_space(i_addr_ext_space),
    .i_bit_sel(i_bit_sel), .o_psd_stored(o_psd_stored),
    .o_psd_display(o_psd_display), .o_privileged(o_privileged),
    .o_blocked(o_blocked), .o_priv_violation(o_priv_violation),
    .o_arith_trap(o_arith_trap), .o_op_accept(o_op_accept),
    .o_trap_taken(o_trap_taken), .o_map_reload(o_map_reload),
    .o_gpr_rdata(o_gpr_rdata), .o_phys_addr(o_phys_addr),
    .o_addr_valid(o_addr_valid), .o_addr_fault(o_addr_fault),
    .o_bit_mask(o_bit_mask)
  );

  // 25 MHz clock
  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end

  // Expected doubleword from its fields, unused bits left zero
  function automatic logic [0:63] dw(input logic p, x, m,
    input logic [1:0] g, input logic r, input logic [1:0] ic);
    logic [0:63] d;
    d = '0;
    {d[0], d[5], d[7], d[32:33], d[47], d[48:49]} = {p, x, m, g, r, ic};
    return d;
  endfunction

  // Stored copy drops display-only and unused bits
  function automatic logic [0:63] keepm(input logic [0:63] s);
    logic [0:63] d;
    d = s;
    {d[8:12], d[31], d[46], d[62:63]} = '0;
    return d;
  endfunction

  // Display copy adds mode, mapped and blocked bits
  function automatic logic [0:63] disp(input logic [0:63] s, input logic b);
    logic [0:63] d;
    d = s;
    {d[8], d[9], d[31]} = {1'b1, |s[32:33], b};
    return d;
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  // Drop every pulse one cycle after it was raised
  task automatic fire();
    @(negedge i_mclk);
    {i_load_status_instruction, i_trap_req, i_svc_call, i_cc_we, i_set_ext} = '0;
    {i_clear_ext, i_instr_done, i_instr_valid, i_gpr_we, i_addr_req} = '0;
    {i_op_map_write, i_op_halt, i_op_wcs_write} = '0;
  endtask

  task automatic load(input logic [0:63] d);
    @(negedge i_mclk);
    {i_load_status_instruction, i_load_status_instruction_psd} = {1'b1, d};
    fire();
  endtask

  task automatic map_wr(input logic [6:0] idx, input logic [10:0] blk);
    @(negedge i_mclk);
    {i_instr_valid, i_op_map_write} = 2'b11;
    {i_map_wr_index, i_map_wr_block} = {idx, blk};
    fire();
  endtask

  // Answer is a one-cycle pulse, so it is polled at every falling edge
  task automatic xlate(input logic [23:0] a, input logic f, x);
    int k;
    @(negedge i_mclk);
    {i_addr_req, i_addr, i_addr_fetch, i_addr_ext_space} = {1'b1, a, f, x};
    fire();
    k = 0;
    while (o_addr_valid !== 1'b1 && k < 4) begin
      @(negedge i_mclk);
      k++;
    end
    {ph, fl} = {o_phys_addr, o_addr_fault};
    `CMP(o_addr_valid, 1'b1, "no address answer")
  endtask

  task automatic t_reset();
    `CMP(o_psd_stored, RST_DW, "reset word")
    `CMP(o_privileged, 1'b1, "reset privilege")
    `CMP(o_psd_display, disp(RST_DW, 1'b0), "reset display")
    `CMP(o_gpr_rdata, 32'h0000_0000, "reset register")
    done("reset");
  endtask

  task automatic t_load();
    logic [1:0] codes [4];
    logic eblk [4];
    logic [0:63] d;
    codes = '{2'b01, 2'b10, 2'b00, 2'b11};
    eblk = '{1'b1, 1'b1, 1'b0, 1'b0};
    d = 64'hFFFF_FFFF_FFFF_FFFF;
    load(d);
    `CMP(o_psd_stored, keepm(d), "unused bits")
    `CMP(o_psd_display, disp(keepm(d), 1'b0), "display bits")
    `CMP(o_map_reload, 1'b0, "map kept")
    for (int i = 0; i < 4; i++) begin
      d = dw(1'b1, 1'b0, 1'b0, 2'b00, i[0], codes[i]);
      load(d);
      `CMP(o_psd_stored, d, "loaded word")
      `CMP(o_blocked, eblk[i], "blocking")
      `CMP(o_psd_display, disp(d, eblk[i]), "blocked shown")
      `CMP(o_map_reload, ~i[0], "map reload")
    end
    done("load");
  endtask

  task automatic t_fields();
    load(dw(1'b1, 1'b0, 1'b1, 2'b00, 1'b1, 2'b00));
    @(negedge i_mclk);
    {i_cc_we, i_cc_flags, i_set_ext, i_instr_done} = {1'b1, 4'hA, 2'b11};
    {i_instr_right_half, i_next_right_half} = 2'b11;
    i_next_word_addr = 17'h1ABCD;
    fire();
    `CMP(o_psd_stored[1:4], 4'hA, "flags")
    `CMP(o_psd_stored[5:6], 2'b11, "ext and last half")
    `CMP(o_psd_stored[13:29], 17'h1ABCD, "word address")
    `CMP(o_psd_stored[30], 1'b1, "next right half")
    `CMP(o_arith_trap, 1'b1, "trap on exception")
    @(negedge i_mclk);
    {i_cc_we, i_cc_flags, i_clear_ext, i_instr_done} = {1'b1, 4'h1, 2'b11};
    {i_instr_right_half, i_next_right_half, i_next_word_addr} = '0;
    fire();
    `CMP(o_psd_stored[1:7], 7'b0001001, "cleared fields")
    `CMP({o_psd_stored[30], o_arith_trap}, 2'b00, "no trap")
    @(negedge i_mclk);
    {i_set_ext, i_clear_ext} = 2'b11;
    fire();
    `CMP(o_psd_stored[5], 1'b1, "set wins")
    load(dw(1'b1, 1'b0, 1'b0, 2'b00, 1'b1, 2'b00));
    @(negedge i_mclk);
    {i_cc_we, i_cc_flags} = {1'b1, 4'h8};
    fire();
    `CMP(o_arith_trap, 1'b0, "masked exception")
    done("fields");
  endtask

  task automatic t_priv();
    load(dw(1'b1, 1'b0, 1'b0, 2'b01, 1'b1, 2'b00));
    map_wr(7'h05, 11'h2A5);
    `CMP(o_op_accept, 1'b1, "privileged map write")
    load(dw(1'b0, 1'b0, 1'b0, 2'b01, 1'b1, 2'b00));
    `CMP(o_privileged, 1'b0, "dropped privilege")
    for (int k = 0; k < 3; k++) begin
      @(negedge i_mclk);
      i_instr_valid = 1'b1;
      {i_op_map_write, i_op_halt, i_op_wcs_write} = 3'b100 >> k;
      i_map_wr_block = 11'h155;
      fire();
      `CMP({o_priv_violation, o_op_accept}, 2'b10, "refused op")
    end
    @(negedge i_mclk);
    i_instr_valid = 1'b1;
    fire();
    `CMP({o_priv_violation, o_op_accept}, 2'b01, "plain op")
    load(RST_DW);
    `CMP({o_priv_violation, o_privileged}, 2'b10, "load refused")
    xlate({5'h00, 6'h05, 13'h0ABC}, 1'b1, 1'b0);
    `CMP({ph, fl}, {11'h2A5, 13'h0ABC, 1'b0}, "mapped fetch")
    @(negedge i_mclk);
    {vec_sel, i_trap_req, i_svc_call} = 3'b011;
    fire();
    `CMP({o_privileged, o_trap_taken}, 2'b11, "trap entry")
    `CMP(o_psd_stored, 64'h8400_0000_0000_4000, "trap word")
    `CMP({o_blocked, o_map_reload}, 2'b11, "trap side effects")
    load(dw(1'b0, 1'b0, 1'b0, 2'b00, 1'b1, 2'b00));
    @(negedge i_mclk);
    {vec_sel, i_svc_call} = 2'b11;
    fire();
    `CMP(o_psd_stored, 64'h8000_0000_0001_0000, "call word")
    `CMP({o_privileged, o_blocked}, 2'b10, "call entry")
    done("privilege");
  endtask

  task automatic t_addr();
    load(dw(1'b1, 1'b0, 1'b0, 2'b00, 1'b1, 2'b00));
    xlate(24'h07FFFF, 1'b0, 1'b0);
    `CMP({ph, fl}, {24'h07FFFF, 1'b0}, "basic top")
    xlate(24'h080000, 1'b1, 1'b0);
    `CMP(fl, 1'b1, "basic beyond")
    load(dw(1'b1, 1'b1, 1'b0, 2'b00, 1'b1, 2'b00));
    xlate(24'hABCDE0, 1'b0, 1'b0);
    `CMP({ph, fl}, {24'hABCDE0, 1'b0}, "extended operand")
    xlate(24'h080000, 1'b1, 1'b0);
    `CMP(fl, 1'b1, "extended fetch")
    map_wr(7'h43, 11'h7F1);
    load(dw(1'b1, 1'b1, 1'b0, 2'b10, 1'b1, 2'b00));
    xlate({5'h00, 6'h03, 13'h0123}, 1'b0, 1'b1);
    `CMP({ph, fl}, {11'h7F1, 13'h0123, 1'b0}, "second space")
    xlate({5'h00, 6'h03, 13'h0123}, 1'b1, 1'b1);
    `CMP(fl, 1'b1, "fetch from second space")
    for (int i = 0; i < 8; i++) begin
      @(negedge i_mclk);
      i_bit_sel = i[2:0];
      @(negedge i_mclk);
      `CMP(o_bit_mask, 8'h80 >> i, "bit select")
    end
    done("addressing");
  endtask

  task automatic t_gpr();
    @(negedge i_mclk);
    {i_gpr_we, i_gpr_waddr, i_gpr_wdata} = {1'b1, 3'h7, 32'hDEAD_BEEF};
    i_gpr_raddr = 3'h7;
    fire();
    @(negedge i_mclk);
    `CMP(o_gpr_rdata, 32'hDEAD_BEEF, "register write")
    i_rst = 1'b1;
    @(negedge i_mclk);
    `CMP(o_psd_stored, RST_DW, "reset in run")
    @(negedge i_mclk);
    i_rst = 1'b0;
    repeat (2) @(negedge i_mclk);
    `CMP({o_gpr_rdata, o_privileged}, {32'h0, 1'b1}, "cleared")
    done("registers");
  endtask

  // Main sequence; reset held for two cycles
  initial begin
    {i_rst, vec_sel, i_instr_done, i_instr_right_half} = 4'b1000;
    {i_next_right_half, i_next_word_addr, i_cc_flags, i_bit_sel} = '0;
    {i_op_map_write, i_op_halt, i_op_wcs_write, i_map_wr_index} = '0;
    {i_map_wr_block, i_load_status_instruction_psd, i_gpr_waddr, i_gpr_wdata} = '0;
    {i_addr, i_addr_fetch, i_addr_ext_space} = '0;
    i_gpr_raddr = 3'h3;
    fire();
    @(negedge i_mclk);
    i_rst = 1'b0;
    repeat (2) @(negedge i_mclk);
    t_reset();
    t_load();
    t_fields();
    t_priv();
    t_addr();
    t_gpr();
    wrap_up();
  end

  // Whole run needs about a hundred cycles; this bound of 2000 is far beyond
  initial begin
    #(40 * 2000);
    bad_count++;
    $display("mismatch at %0t: run did not finish", $time);
    wrap_up();
  end
endmodule
